// ### include/azt_pkg.sv
// How it works
// RL1 - block input is sampled once at each processing cycle start, used throughout
// RL2 - blocking comes from the matrix on its own dedicated input port
// RL3 - zone pick-up with block inactive raises that zone's trip
// RL4 - zone pick-up with block active raises blocked, event then ignored
// RL5 - blocking source must assert at least 5 ms before the operating delay ends
// RL6 - mode reported as on, blocked, test, test-and-blocked or off
// RL7 - condition word holds trip and blocked bits for all four zones
// RL8 - flags: phase and residual blocked/started, light and pressure per channel
// RL9 - zone pick-up built only from sources enabled for that zone; current-in mode here takes any light or pressure channel
// RL10 - current-in digital input mode needs digital input and a sensor together
// RL11 - each zone decided independently of every other zone
package azt_pkg;
    localparam int          NUM_ZONES       = 4;
    localparam int          NUM_CHANNELS    = 4;
    // register byte addresses
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_ZONE_BASE  = 8'h04;   // four words, one per zone
    localparam logic [7:0]  ADDR_COND       = 8'h14;
    localparam logic [7:0]  ADDR_FLAGS      = 8'h18;
    localparam logic [7:0]  ADDR_MODE       = 8'h1c;
    localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h20;
    localparam logic [7:0]  ADDR_IRQ_EN     = 8'h24;
    localparam logic [7:0]  ADDR_IRQ_CLR    = 8'h28;
    // control fields
    localparam int          CTRL_ENABLE_BIT = 0;
    localparam int          CTRL_TEST_BIT   = 1;
    localparam logic [1:0]  CTRL_RESET      = 2'h0;
    // zone configuration fields
    localparam int          ZC_ZONE_EN      = 0;
    localparam int          ZC_PH_EN        = 1;
    localparam int          ZC_RES_EN       = 2;
    localparam int          ZC_LIGHT_LSB    = 3;
    localparam int          ZC_PRES_LSB     = 7;
    localparam int          ZC_DI_LSB       = 11;
    localparam int          ZC_WIDTH        = 13;
    localparam logic [12:0] ZC_RESET        = 13'h0000;
    // digital input modes
    localparam logic [1:0]  DI_DISABLED     = 2'h0;
    localparam logic [1:0]  DI_LIGHT_IN     = 2'h1;
    localparam logic [1:0]  DI_CURRENT_IN   = 2'h2;
    // flag word positions
    localparam int          FL_PH_BLOCKED   = 0;
    localparam int          FL_PH_START     = 1;
    localparam int          FL_RES_BLOCKED  = 2;
    localparam int          FL_RES_START    = 3;
    localparam int          FL_LIGHT_LSB    = 4;
    localparam int          FL_PRES_LSB     = 8;
    // interrupt layout: bits 3:0 zone trip, 7:4 zone blocked
    localparam logic [7:0]  IRQ_RESET       = 8'h00;
    // timing
    localparam int          CLK_FREQ_HZ     = 100_000_000;
    localparam int          CYCLE_CLKS_DEF  = 500;        // processing cycle, 5 us
    localparam int          BLOCK_LEAD_MS   = 5;
    localparam int          BLOCK_LEAD_CLKS = BLOCK_LEAD_MS * (CLK_FREQ_HZ / 1000);
    // bus answers
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [2:0] {
        AZT_MODE_ON          = 3'b000,
        AZT_MODE_BLOCKED     = 3'b001,
        AZT_MODE_TEST        = 3'b010,
        AZT_MODE_TEST_BLOCKED = 3'b011,
        AZT_MODE_OFF         = 3'b100
    } azt_mode_t;
endpackage

// ### hdl/azt_arc_zone.sv
module azt_arc_zone #(
    parameter int CYCLE_CLKS = azt_pkg::CYCLE_CLKS_DEF
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    // pick-up sources and blocking from the same clock domain
    input  wire logic        block_in,
    input  wire logic        phase_overcurrent_flag,
    input  wire logic        residual_overcurrent_flag,
    input  wire logic [3:0]  light_detect,
    input  wire logic [3:0]  pressure_detect,
    input  wire logic [3:0]  zone_digital_in,
    output logic      [3:0]  zone_trip,
    output logic             irq,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam int CW = $clog2(CYCLE_CLKS + 1);

    typedef struct packed {
        logic [CW-1:0]      cyc;
        logic               blk_s;
        logic [1:0]         ctrl;
        logic [3:0][12:0]   zcfg;
        logic [3:0]         trip;
        logic [3:0]         blkd;
        logic [3:0]         held;
        logic [3:0]         pin;          // trip image driven onto the pins
        logic [11:0]        flags;
        logic [2:0]         mode;
        logic [7:0]         irq_st;
        logic [7:0]         irq_en;
        logic               irq;
        logic               aw_held;
        logic [7:0]         awaddr;
        logic               w_held;
        logic [31:0]        wdata;
        logic [3:0]         wstrb;
        logic               awready;
        logic               wready;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               arready;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
    } azt_state_t;

    azt_state_t st;
    azt_state_t next_st;

    logic [3:0] pickup;

    // merge write data into a word by byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // zone index of a zone configuration address, 4 when not one
    function automatic logic [2:0] zone_of(input logic [7:0] a);
        logic [2:0] z;
        z = 3'h4;
        for (int i = 0; i < 4; i++) begin
            if (a == azt_pkg::ADDR_ZONE_BASE + 8'(4 * i)) begin
                z = 3'(i);
            end
        end
        return z;
    endfunction

    // status words that software may read but not change
    function automatic logic read_only(input logic [7:0] a);
        return a == azt_pkg::ADDR_COND || a == azt_pkg::ADDR_FLAGS
            || a == azt_pkg::ADDR_MODE || a == azt_pkg::ADDR_IRQ_STAT;
    endfunction

    // per-zone pick-up from its enabled sources, except current-in mode which accepts any channel
    genvar gz;
    generate
        for (gz = 0; gz < 4; gz++) begin : g_zone
            logic [12:0] c;
            logic        sens;
            logic        oc_ok;
            logic        any_ch;
            logic [1:0]  dim;
            assign c      = st.zcfg[gz];
            assign dim    = c[azt_pkg::ZC_DI_LSB +: 2];
            // RL9 enabled sources
            assign sens   = |(light_detect & c[azt_pkg::ZC_LIGHT_LSB +: 4])
                          | |(pressure_detect & c[azt_pkg::ZC_PRES_LSB +: 4]);
            // current gate applies only when a current source is enabled
            assign oc_ok  = !(c[azt_pkg::ZC_PH_EN] || c[azt_pkg::ZC_RES_EN])
                          || (c[azt_pkg::ZC_PH_EN] && phase_overcurrent_flag)
                          || (c[azt_pkg::ZC_RES_EN] && residual_overcurrent_flag);
            // current-in mode accepts any channel, enabled or not
            assign any_ch = |light_detect | |pressure_detect;
            // RL10 current-in needs a sensor too
            assign pickup[gz] = c[azt_pkg::ZC_ZONE_EN]
                && ((sens && oc_ok)
                 || (dim == azt_pkg::DI_LIGHT_IN && zone_digital_in[gz])
                 || (dim == azt_pkg::DI_CURRENT_IN && zone_digital_in[gz] && any_ch));
        end
    endgenerate

    // next-state logic
    always_comb begin
        logic        tick;
        logic        on;
        logic        blk;
        logic [2:0]  zi;
        logic [31:0] rd;
        logic [7:0]  ev;
        logic [3:0]  new_blk;

        // every field holds unless a branch below moves it
        next_st = st;
        tick    = (st.cyc == CW'(CYCLE_CLKS - 1));
        on      = st.ctrl[azt_pkg::CTRL_ENABLE_BIT];
        blk     = st.blk_s;
        zi      = 3'h4;
        rd      = 32'h0000_0000;
        ev      = 8'h00;
        new_blk = 4'h0;

        // processing cycle counter
        next_st.cyc = tick ? '0 : st.cyc + CW'(1);

        if (tick) begin
            // RL1 RL2 sample dedicated block
            blk           = block_in;
            next_st.blk_s = block_in;
            for (int z = 0; z < 4; z++) begin
                // RL11 zone decided alone
                if (!on || !pickup[z]) begin
                    next_st.trip[z] = 1'b0;
                    next_st.blkd[z] = 1'b0;
                    next_st.held[z] = 1'b0;
                end else if (blk || st.held[z]) begin
                    // RL4 blocked, event dropped
                    next_st.trip[z] = st.trip[z];
                    next_st.blkd[z] = 1'b1;
                    next_st.held[z] = !st.trip[z];
                    new_blk[z]      = !st.blkd[z];
                end else begin
                    // RL3 trip when unblocked
                    next_st.trip[z] = 1'b1;
                    next_st.blkd[z] = 1'b0;
                end
            end
            // events: blocked rising in the high half, trip rising low
            ev = {new_blk, next_st.trip & ~st.trip};
            // RL8 sensor and overcurrent flags
            next_st.flags = {pressure_detect, light_detect,
                             residual_overcurrent_flag, residual_overcurrent_flag && blk,
                             phase_overcurrent_flag, phase_overcurrent_flag && blk};
            // RL6 operating mode
            if (!on) begin
                next_st.mode = azt_pkg::AZT_MODE_OFF;
            end else begin
                next_st.mode = {1'b0, st.ctrl[azt_pkg::CTRL_TEST_BIT], blk};
            end
        end

        // pins follow trips only in the normal operating mode
        next_st.pin = next_st.trip & {4{next_st.mode == azt_pkg::AZT_MODE_ON}};

        // axi write channels taken in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_held = 1'b1;
            next_st.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_held = 1'b1;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // write commit; status set wins over clear
        next_st.irq_st = st.irq_st | ev;
        if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = azt_pkg::RESP_OKAY;
            zi              = zone_of(st.awaddr);
            if (st.awaddr == azt_pkg::ADDR_CTRL) begin
                // enable and test bits
                next_st.ctrl = 2'(merge({30'h0, st.ctrl}, st.wdata, st.wstrb));
            end else if (zi != 3'h4) begin
                // zone source selection word
                next_st.zcfg[zi[1:0]] = 13'(merge({19'h0, st.zcfg[zi[1:0]]},
                                                  st.wdata, st.wstrb));
            end else if (st.awaddr == azt_pkg::ADDR_IRQ_EN) begin
                // interrupt enable mask
                next_st.irq_en = 8'(merge({24'h0, st.irq_en}, st.wdata, st.wstrb));
            end else if (st.awaddr == azt_pkg::ADDR_IRQ_CLR) begin
                // write one to clear, a new event still sets
                if (st.wstrb[0]) begin
                    next_st.irq_st = (st.irq_st & ~st.wdata[7:0]) | ev;
                end
            end else if (!read_only(st.awaddr)) begin
                next_st.bresp = azt_pkg::RESP_SLVERR;
            end
        end

        // ready again once the slot and the answer are free
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready  = !next_st.w_held && !next_st.bvalid;
        // level interrupt from the updated status
        next_st.irq     = |(next_st.irq_st & next_st.irq_en);

        // axi read
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = azt_pkg::RESP_OKAY;
            zi             = zone_of(s_axi_araddr);
            case (s_axi_araddr)
                azt_pkg::ADDR_CTRL:     rd = {30'h0, st.ctrl};
                // RL7 condition word
                azt_pkg::ADDR_COND:     rd = {24'h0, st.blkd[3], st.trip[3], st.blkd[2],
                                              st.trip[2], st.blkd[1], st.trip[1],
                                              st.blkd[0], st.trip[0]};
                azt_pkg::ADDR_FLAGS:    rd = {20'h0, st.flags};
                azt_pkg::ADDR_MODE:     rd = {29'h0, st.mode};
                azt_pkg::ADDR_IRQ_STAT: rd = {24'h0, st.irq_st};
                azt_pkg::ADDR_IRQ_EN:   rd = {24'h0, st.irq_en};
                azt_pkg::ADDR_IRQ_CLR:  rd = 32'h0000_0000;
                default: begin
                    if (zi != 3'h4) begin
                        rd = {19'h0, st.zcfg[zi[1:0]]};
                    end else begin
                        next_st.rresp = azt_pkg::RESP_SLVERR;
                    end
                end
            endcase
            next_st.rdata = rd;
        end
        // one read in flight at a time
        next_st.arready = !next_st.rvalid;
    end

    // state register, frozen while clock enable is low
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            // power-up values of every field
            st        <= '0;
            st.ctrl   <= azt_pkg::CTRL_RESET;
            st.zcfg   <= {4{azt_pkg::ZC_RESET}};
            st.mode   <= azt_pkg::AZT_MODE_OFF;
            st.irq_st <= azt_pkg::IRQ_RESET;
            st.irq_en <= azt_pkg::IRQ_RESET;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // outputs straight from the state register; test mode holds trips off the pins
    assign zone_trip     = st.pin;
    assign irq           = st.irq;

    // write channel handshake and answer
    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;

    // read channel handshake and answer
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
endmodule

// ### testbench/azt_arc_zone_asserts.sv
module azt_arc_zone_asserts #(
    parameter int CYCLE_CLKS = azt_pkg::CYCLE_CLKS_DEF
) (
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        clk_en,
    input wire logic        block_in,
    input wire logic [3:0]  zone_trip,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt;
    logic        tk;
    // processing-cycle tick rebuilt from the ports
    assign tk = clk_en && (cnt == 16'(CYCLE_CLKS - 1));
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 16'h0000;
        end else if (clk_en) begin
            cnt <= tk ? 16'h0000 : cnt + 16'h0001;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_trip_at_tick: assert property ($changed(zone_trip) |-> $past(tk))
        else $error("zone trip moved between ticks");
    a_block_no_trip: assert property (($past(tk) && $past(block_in)) |->
        ((zone_trip & ~$past(zone_trip)) == 4'h0)) else $error("trip rose while blocked");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready && clk_en |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready && clk_en |=>
        s_axi_rvalid) else $error("no read answer");
endmodule

bind azt_arc_zone azt_arc_zone_asserts #(.CYCLE_CLKS(CYCLE_CLKS)) chk_u (.core_clk, .arst_n,
    .clk_en, .block_in, .zone_trip, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// ### testbench/azt_src_model.sv
module azt_src_model #(
    parameter int C = 4
) (
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic [14:0] want,
    output logic            block_in,
    output logic            ph_oc,
    output logic            res_oc,
    output logic [3:0]      light,
    output logic [3:0]      pres,
    output logic [3:0]      din
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt = 16'h0000;
    logic [14:0] q   = 15'h0000;
    assign {block_in, ph_oc, res_oc, light, pres, din} = q;
    // block lead: levels move one clock before the sampling tick
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 16'h0000;
            q   <= 15'h0000;
        end else begin
            cnt <= (cnt == 16'(C - 1)) ? 16'h0000 : cnt + 16'h0001;
            if (cnt == 16'(C / 2)) q <= want;
        end
    end
endmodule

// ### testbench/azt_arc_zone_tb_top.sv
module azt_arc_zone_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int         C  = 4;
    localparam logic [1:0] OK = azt_pkg::RESP_OKAY;
    localparam logic [1:0] SE = azt_pkg::RESP_SLVERR;
    logic        core_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1;
    logic        block_in, ph_oc, res_oc, irq;
    logic [3:0]  light, pres, din, zone_trip, s_axi_wstrb = 4'hf;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [14:0] want = 15'h0000;
    int          n_fail = 0;
    int          n_tests = 0;
    logic [1:0]  mc [5] = '{2'h1, 2'h1, 2'h3, 2'h3, 2'h0};
    logic        mb [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [2:0]  mm [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    // clock
    always #5 core_clk = ~core_clk;
    azt_src_model #(.C(C)) src_u (.core_clk, .arst_n, .want, .block_in, .ph_oc, .res_oc,
        .light, .pres, .din);
    azt_arc_zone #(.CYCLE_CLKS(C)) dut_u (.core_clk, .arst_n, .clk_en, .block_in,
        .phase_overcurrent_flag(ph_oc), .residual_overcurrent_flag(res_oc),
        .light_detect(light), .pressure_detect(pres), .zone_digital_in(din), .zone_trip,
        .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    task automatic tally_and_finish();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("Error at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // write cycle, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit done;
        done = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        for (int i = 0; i < 200 && !done; i++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            // answer left waiting one cycle before it is taken
            if (s_axi_bvalid && s_axi_bready) begin
                chk(32'(s_axi_bresp), 32'(er));
                done = 1'b1;
            end else if (s_axi_bvalid) begin
                s_axi_bready <= 1'b1;
            end
        end
        s_axi_bready <= 1'b0;
        if (!done) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit done;
        done = 1'b0;
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        for (int i = 0; i < 200 && !done; i++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            // answer left waiting one cycle before it is taken
            if (s_axi_rvalid && s_axi_rready) begin
                chk(s_axi_rdata, ed);
                chk(32'(s_axi_rresp), 32'(er));
                done = 1'b1;
            end else if (s_axi_rvalid) begin
                s_axi_rready <= 1'b1;
            end
        end
        s_axi_rready <= 1'b0;
        if (!done) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    // new source levels, then let three ticks pass
    task automatic st(input logic [14:0] w);
        @(posedge core_clk);
        want <= w;
        repeat (3 * C) @(posedge core_clk);
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        // reset values and unmapped place
        for (int a = 0; a <= 'h28; a += 4) rd(8'(a), (a == 'h1c) ? 32'h4 : 32'h0, OK);
        rd(8'h40, 32'h0, SE);
        wr(8'h40, 32'h1, SE);
        // every reported mode
        for (int i = 0; i < 5; i++) begin
            wr(azt_pkg::ADDR_CTRL, 32'(mc[i]), OK);
            st({mb[i], 14'h0000});
            rd(azt_pkg::ADDR_MODE, 32'(mm[i]), OK);
        end
        wr(azt_pkg::ADDR_CTRL, 32'h1, OK);
        wr(azt_pkg::ADDR_IRQ_EN, 32'hff, OK);
        wr(8'h04, 32'h9, OK);
        wr(8'h08, 32'h11, OK);
        wr(8'h0c, 32'hb, OK);
        wr(8'h10, 32'h1001, OK);
        // light on channel one only
        st(15'h0100);
        chk(32'(zone_trip), 32'h1);
        rd(azt_pkg::ADDR_COND, 32'h1, OK);
        rd(azt_pkg::ADDR_FLAGS, 32'h10, OK);
        chk(32'(irq), 32'h1);
        st(15'h2100);
        chk(32'(zone_trip), 32'h5);
        rd(azt_pkg::ADDR_COND, 32'h11, OK);
        rd(azt_pkg::ADDR_FLAGS, 32'h12, OK);
        // mask then clear the interrupt
        wr(azt_pkg::ADDR_IRQ_EN, 32'h0, OK);
        repeat (2) @(posedge core_clk);
        chk(32'(irq), 32'h0);
        rd(azt_pkg::ADDR_IRQ_STAT, 32'h5, OK);
        wr(azt_pkg::ADDR_IRQ_CLR, 32'hff, OK);
        rd(azt_pkg::ADDR_IRQ_STAT, 32'h0, OK);
        st(15'h0000);
        // pick-up while blocked, then block released
        st(15'h6100);
        chk(32'(zone_trip), 32'h0);
        rd(azt_pkg::ADDR_COND, 32'h22, OK);
        rd(azt_pkg::ADDR_FLAGS, 32'h13, OK);
        rd(azt_pkg::ADDR_IRQ_STAT, 32'h50, OK);
        st(15'h2100);
        chk(32'(zone_trip), 32'h0);
        // digital input in current-in mode
        st(15'h0008);
        chk(32'(zone_trip), 32'h0);
        st(15'h0018);
        chk(32'(zone_trip), 32'h8);
        wr(azt_pkg::ADDR_CTRL, 32'h3, OK);
        st(15'h0018);
        chk(32'(zone_trip), 32'h0);
        rd(azt_pkg::ADDR_COND, 32'h40, OK);
        // digital input in light-in mode trips the zone alone
        wr(8'h0c, 32'h801, OK);
        wr(azt_pkg::ADDR_CTRL, 32'h1, OK);
        st(15'h0004);
        chk(32'(zone_trip), 32'h4);
        // clock enable low freezes every decision
        @(posedge core_clk);
        clk_en <= 1'b0;
        st(15'h0000);
        chk(32'(zone_trip), 32'h4);
        clk_en <= 1'b1;
        tally_and_finish();
    end
endmodule
